// File: rtl/pmic_gpio_and_sleep_control.sv
// pin control, command strobes and low-power disables
// assumes register accesses arrive already decoded by the 2-wire interface
// How it works
// - writing wake bit starts wake-up from hold state; bit self-clears
// - writing shutdown bit powers down to reset mode; bit self-clears
// - writing watchdog bit restarts the watchdog; bit self-clears
// - domain-input disable ignores system, power, power1 requests in hold state
// - calendar hold bit stops calendar updates during hold state
// - serial port sleep bit turns off the 2-wire interface in hold state
// - input event disable blocks input events during hold state
// - wake disable zero lets passive-to-active input transitions wake the device
// - input polarity one means active high, zero active low
// - pin 0 codes: watchdog trigger, input, open-drain, push-pull
// - pins 1 and 3: reserved, input, open-drain, push-pull
// - pin 2: power request, input, open-drain, push-pull supply fault
// - pin 4: system request, input, open-drain, push-pull
// - wake sensitivity zero is edge, one is level
// - mode bit: static value, output polarity, or input debounce enable
// - source select: static, supply fault, sequencer; code two reserved
// - pin 1 forwards inputs 0, 2, 3 on codes 100, 110, 111
// - pin 0 forwards inputs 1, 2, 3 on codes 101, 110, 111
// - enabled debounce applies the shared time from none to 1024 ms
// - pin 4 two-bit select: static, fault, reserved, sequencer
// - pin 3 forwards inputs 0, 1, 2 on codes 100, 101, 110
// - each input event has a mask keeping it off the interrupt
`include "pmic_gpio_defs.svh"

module pmic_gpio_and_sleep_control #(
    parameter int NPINS = 5,
    parameter int DEB_TICK_CYCLES = `DEB_TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port from the 2-wire interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // pins
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    // from the sequencer and supervisors
    input wire logic low_power_hold_state,
    input wire logic supply_fault_indication,
    input wire logic [NPINS-1:0] seq_pin_ctrl,
    input wire logic power1_domain_request_in,
    // commands to the sequencer and watchdog
    output logic wake_request,
    output logic shutdown_request,
    output logic watchdog_service,
    output logic watchdog_trigger,
    // domain requests
    output logic system_domain_request,
    output logic power_domain_request,
    output logic power1_domain_request,
    // hold-state disables
    output logic calendar_hold,
    output logic serial_port_off,
    // input events and state
    output logic [NPINS-1:0] input_event,
    output logic input_event_irq,
    output logic [NPINS-1:0] gpi_state
);

    localparam int CNT_W = 17;
    localparam int TICK_W = $clog2(DEB_TICK_CYCLES + 1);

    // debounce length in ticks for the shared time select
    function automatic logic [CNT_W-1:0] deb_limit(input logic [2:0] sel);
        logic [CNT_W-1:0] r;
        r = '0;
        unique case (sel)
            3'h0: r = '0;
            3'h1: r = CNT_W'(`DEB_T1_US / `DEB_TICK_US);
            3'h2: r = CNT_W'(`DEB_T2_US / `DEB_TICK_US);
            3'h3: r = CNT_W'(`DEB_T3_US / `DEB_TICK_US);
            3'h4: r = CNT_W'(`DEB_T4_US / `DEB_TICK_US);
            3'h5: r = CNT_W'(`DEB_T5_US / `DEB_TICK_US);
            3'h6: r = CNT_W'(`DEB_T6_US / `DEB_TICK_US);
            3'h7: r = CNT_W'(`DEB_T7_US / `DEB_TICK_US);
        endcase
        return r;
    endfunction

    // output level for a source select; reserved codes drive low
    function automatic logic src_level(input logic [2:0] sel, input logic mode,
                                       input logic fault, input logic seq,
                                       input logic [3:0] fwd);
        logic raw;
        logic ok;
        raw = 1'b0;
        ok = 1'b1;
        case (sel)
            `SRC_FAULT: raw = fault;
            `SRC_SEQ: raw = seq;
            3'h4, 3'h5, 3'h6, 3'h7: raw = fwd[2'(sel - `SRC_FWD_BASE)];
            default: ok = 1'b0;
        endcase
        if (sel == `SRC_STATIC) begin
            return mode;
        end
        // non-static sources: mode bit picks the active level
        return ok && (mode ? raw : !raw);
    endfunction

    // registers
    logic [2:0] cmd_q;
    logic [7:0] sleep_q;
    logic [7:0] cfg01_q;
    logic [7:0] cfg23_q;
    logic [3:0] cfg4_q;
    logic [4:0] wake_sens_q;
    logic [4:0] mode_q;
    logic [7:0] out02_q;
    logic [4:0] out34_q;
    logic [2:0] deb_sel_q;
    logic [4:0] mask_q;

    wire logic wr_cmd = reg_wr && (reg_addr == `ADDR_CMD_STROBES);
    wire logic wr_sleep = reg_wr && (reg_addr == `ADDR_SLEEP_DIS);
    wire logic wr_cfg01 = reg_wr && (reg_addr == `ADDR_PINS_01);
    wire logic wr_cfg23 = reg_wr && (reg_addr == `ADDR_PINS_23);
    wire logic wr_cfg4 = reg_wr && (reg_addr == `ADDR_PIN_4);
    wire logic wr_wake = reg_wr && (reg_addr == `ADDR_WAKE_SENS);
    wire logic wr_mode = reg_wr && (reg_addr == `ADDR_MODE_BITS);
    wire logic wr_out02 = reg_wr && (reg_addr == `ADDR_OUT_SRC_02);
    wire logic wr_out34 = reg_wr && (reg_addr == `ADDR_OUT_SRC_34);
    wire logic wr_deb = reg_wr && (reg_addr == `ADDR_DEBOUNCE);
    wire logic wr_mask = reg_wr && (reg_addr == `ADDR_EVENT_MASK);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sleep_q <= `RST_BYTE;
            cfg01_q <= `RST_BYTE;
            cfg23_q <= `RST_BYTE;
            cfg4_q <= 4'h0;
            wake_sens_q <= 5'h00;
            mode_q <= 5'h00;
            out02_q <= `RST_BYTE;
            out34_q <= 5'h00;
            deb_sel_q <= 3'h0;
            mask_q <= 5'h00;
        end else begin
            if (wr_sleep) sleep_q <= reg_wdata & `SLP_RW_MASK;
            if (wr_cfg01) cfg01_q <= reg_wdata;
            if (wr_cfg23) cfg23_q <= reg_wdata;
            if (wr_cfg4) cfg4_q <= reg_wdata[3:0];
            if (wr_wake) wake_sens_q <= reg_wdata[4:0];
            if (wr_mode) mode_q <= reg_wdata[4:0];
            if (wr_out02) out02_q <= reg_wdata;
            if (wr_out34) out34_q <= reg_wdata[4:0];
            if (wr_deb) deb_sel_q <= reg_wdata[2:0];
            if (wr_mask) mask_q <= reg_wdata[4:0];
        end
    end

    // strobes hold for one cycle only, so a read sees one at most once
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_q <= 3'h0;
        end else begin
            cmd_q <= wr_cmd ? reg_wdata[2:0] : 3'h0;
        end
    end

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `ADDR_CMD_STROBES: rd_mux = {5'h00, cmd_q};
            `ADDR_SLEEP_DIS: rd_mux = sleep_q;
            `ADDR_PINS_01: rd_mux = cfg01_q;
            `ADDR_PINS_23: rd_mux = cfg23_q;
            `ADDR_PIN_4: rd_mux = {4'h0, cfg4_q};
            `ADDR_WAKE_SENS: rd_mux = {3'h0, wake_sens_q};
            `ADDR_MODE_BITS: rd_mux = {3'h0, mode_q};
            `ADDR_OUT_SRC_02: rd_mux = out02_q;
            `ADDR_OUT_SRC_34: rd_mux = {3'h0, out34_q};
            `ADDR_DEBOUNCE: rd_mux = {5'h00, deb_sel_q};
            `ADDR_EVENT_MASK: rd_mux = {3'h0, mask_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // per-pin configuration
    pmic_gpio_pkg::pin_cfg_t cfg [NPINS];
    logic [2:0] sel [NPINS];
    assign cfg[0] = pmic_gpio_pkg::pin_cfg_t'(cfg01_q[3:0]);
    assign cfg[1] = pmic_gpio_pkg::pin_cfg_t'(cfg01_q[7:4]);
    assign cfg[2] = pmic_gpio_pkg::pin_cfg_t'(cfg23_q[3:0]);
    assign cfg[3] = pmic_gpio_pkg::pin_cfg_t'(cfg23_q[7:4]);
    assign cfg[4] = pmic_gpio_pkg::pin_cfg_t'(cfg4_q);
    assign sel[0] = out02_q[2:0];
    assign sel[1] = out02_q[5:3];
    // pin 2 push-pull code is the fixed supply fault output
    assign sel[2] = (cfg[2].pin_function == pmic_gpio_pkg::FN_PUSH_PULL) ?
                    `SRC_FAULT : {1'b0, out02_q[7:6]};
    assign sel[3] = out34_q[2:0];
    assign sel[4] = {1'b0, out34_q[4:3]};

    wire logic in_hold = low_power_hold_state;
    wire logic domain_off = in_hold && sleep_q[`SLP_DOMAIN_BIT];
    wire logic event_off = in_hold && sleep_q[`SLP_EVENT_BIT];

    // synchroniser: second stage is the only reader of the first
    logic [NPINS-1:0] sync1_q;
    logic [NPINS-1:0] sync2_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // shared debounce tick divider
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == TICK_W'(DEB_TICK_CYCLES - 1);
            tick_cnt_q <= (tick_cnt_q == TICK_W'(DEB_TICK_CYCLES - 1)) ?
                          '0 : tick_cnt_q + 1'b1;
        end
    end

    wire logic [CNT_W-1:0] limit = deb_limit(deb_sel_q);
    logic [NPINS-1:0] raw_act;
    logic [NPINS-1:0] act;
    logic [NPINS-1:0] is_input;

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        assign raw_act[i] = sync2_q[i] ^ !cfg[i].input_polarity;
        assign is_input[i] = !cfg[i].pin_function[1];
        input_debounce #(
            .CNT_W(CNT_W)
        ) u_deb (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .tick(tick_q),
            .enable(mode_q[i] && is_input[i]),
            .limit(limit),
            .level_in(raw_act[i]),
            .level_out(act[i])
        );
    end

    // event and wake detection on the cleaned active level
    logic [NPINS-1:0] act_prev_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            act_prev_q <= '0;
        end else begin
            act_prev_q <= act;
        end
    end

    wire logic [NPINS-1:0] rise = act & ~act_prev_q;
    // level mode keeps requesting while the input stays active
    wire logic [NPINS-1:0] wake_hit = is_input &
        (wake_sens_q & act | ~wake_sens_q & rise);
    logic [NPINS-1:0] wake_allow;
    for (genvar i = 0; i < NPINS; i++) begin : g_wen
        assign wake_allow[i] = !cfg[i].pin_wake_disable;
    end
    wire logic pin_wake = in_hold && |(wake_hit & wake_allow);
    wire logic [NPINS-1:0] event_d = event_off ? '0 : (rise & is_input);
    wire logic irq_d = |(event_d & ~mask_q[NPINS-1:0]);

    // pin functions in alternate code
    wire logic pin0_wdog = cfg[0].pin_function == pmic_gpio_pkg::FN_ALT;
    wire logic pin2_pwr = cfg[2].pin_function == pmic_gpio_pkg::FN_ALT;
    wire logic pin4_sys = cfg[4].pin_function == pmic_gpio_pkg::FN_ALT;

    // forwarded inputs per pin, codes 100..111, reserved slots tied low
    logic [3:0] fwd [NPINS];
    assign fwd[0] = {act[3], act[2], act[1], 1'b0};
    assign fwd[1] = {act[3], act[2], 1'b0, act[0]};
    assign fwd[2] = 4'h0;
    assign fwd[3] = {1'b0, act[2], act[1], act[0]};
    assign fwd[4] = 4'h0;

    pmic_gpio_pkg::pin_drive_t drv [NPINS];
    for (genvar i = 0; i < NPINS; i++) begin : g_drv
        wire logic lvl = src_level(sel[i], mode_q[i], supply_fault_indication,
                                   seq_pin_ctrl[i], fwd[i]);
        // open-drain only ever pulls low; high is left to the pull-up
        always_comb begin
            unique case (cfg[i].pin_function)
                pmic_gpio_pkg::FN_OPEN_DRAIN: drv[i] = '{drive: 1'b0, enable: !lvl};
                pmic_gpio_pkg::FN_PUSH_PULL: drv[i] = '{drive: lvl, enable: 1'b1};
                default: drv[i] = '{drive: 1'b0, enable: 1'b0};
            endcase
        end
    end

    // output flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe <= '0;
            wake_request <= 1'b0;
            input_event <= '0;
            input_event_irq <= 1'b0;
            gpi_state <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                pin_out[i] <= drv[i].drive;
                pin_oe[i] <= drv[i].enable;
            end
            wake_request <= (wr_cmd && reg_wdata[`CMD_WAKE_BIT]) || pin_wake;
            input_event <= event_d;
            input_event_irq <= irq_d;
            gpi_state <= act;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            watchdog_trigger <= 1'b0;
            system_domain_request <= 1'b0;
            power_domain_request <= 1'b0;
            power1_domain_request <= 1'b0;
            calendar_hold <= 1'b0;
            serial_port_off <= 1'b0;
        end else begin
            watchdog_trigger <= pin0_wdog && act[0];
            system_domain_request <= !domain_off && pin4_sys && act[4];
            power_domain_request <= !domain_off && pin2_pwr && act[2];
            power1_domain_request <= !domain_off && power1_domain_request_in;
            calendar_hold <= in_hold && sleep_q[`SLP_CALENDAR_BIT];
            serial_port_off <= in_hold && sleep_q[`SLP_SERIAL_BIT];
        end
    end

    assign shutdown_request = cmd_q[`CMD_SHUTDOWN_BIT];
    assign watchdog_service = cmd_q[`CMD_WATCHDOG_BIT];

endmodule

// File: rtl/pmic_gpio_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 9-bit register address from the 2-wire host interface logic
`ifndef PMIC_GPIO_DEFS_SVH
`define PMIC_GPIO_DEFS_SVH

// register offsets
`define ADDR_EVENT_MASK 9'h00c
`define ADDR_DEBOUNCE 9'h010
`define ADDR_CMD_STROBES 9'h013
`define ADDR_SLEEP_DIS 9'h014
`define ADDR_PINS_01 9'h015
`define ADDR_PINS_23 9'h016
`define ADDR_PIN_4 9'h017
`define ADDR_WAKE_SENS 9'h01c
`define ADDR_MODE_BITS 9'h01d
`define ADDR_OUT_SRC_02 9'h01e
`define ADDR_OUT_SRC_34 9'h01f

// command strobe bits
`define CMD_WAKE_BIT 2
`define CMD_SHUTDOWN_BIT 1
`define CMD_WATCHDOG_BIT 0

// sleep disable bits
`define SLP_DOMAIN_BIT 7
`define SLP_CALENDAR_BIT 4
`define SLP_SERIAL_BIT 2
`define SLP_EVENT_BIT 0
`define SLP_RW_MASK 8'h95

// reset values
`define RST_BYTE 8'h00

// source select codes
`define SRC_STATIC 3'h0
`define SRC_FAULT 3'h1
`define SRC_SEQ 3'h3
`define SRC_FWD_BASE 3'h4

// timing: clock period and debounce tick, in ns
`define CLK_PERIOD_NS 10
`define DEB_TICK_NS 10000
`define DEB_TICK_CYCLES (`DEB_TICK_NS / `CLK_PERIOD_NS)

// debounce times in us, printed figures
`define DEB_T1_US 100
`define DEB_T2_US 1000
`define DEB_T3_US 10240
`define DEB_T4_US 51200
`define DEB_T5_US 256000
`define DEB_T6_US 512000
`define DEB_T7_US 1024000
`define DEB_TICK_US (`DEB_TICK_NS / 1000)

`endif

// File: rtl/pmic_gpio_pkg.sv
// types shared by the pin and sleep control logic
// assumes pmic_gpio_defs.svh for the numeric constants
package pmic_gpio_pkg;

    typedef enum logic [1:0] {
        FN_ALT = 2'b00,
        FN_INPUT = 2'b01,
        FN_OPEN_DRAIN = 2'b10,
        FN_PUSH_PULL = 2'b11
    } pin_function_t;

    typedef struct packed {
        logic pin_wake_disable;
        logic input_polarity;
        pin_function_t pin_function;
    } pin_cfg_t;

    typedef struct packed {
        logic drive;
        logic enable;
    } pin_drive_t;

endpackage

// File: rtl/input_debounce.sv
// one input debouncer counting shared slow ticks
// assumes a synchronised input and a one-cycle tick enable
module input_debounce #(
    parameter int CNT_W = 17
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic tick,
    input wire logic enable,
    input wire logic [CNT_W-1:0] limit,
    // data
    input wire logic level_in,
    output logic level_out
);

    logic [CNT_W-1:0] cnt_q;
    logic level_q;

    wire logic differs = level_in != level_q;
    // zero limit or debounce off passes the level straight through
    wire logic bypass = !enable || (limit == '0);
    wire logic settled = tick && (cnt_q + 1'b1 >= limit);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (bypass || !differs) begin
            cnt_q <= '0;
            level_q <= bypass ? level_in : level_q;
        end else if (settled) begin
            cnt_q <= '0;
            level_q <= level_in;
        end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign level_out = level_q;

endmodule

// File: test/pin_world.sv
// pin-side model: pull-ups plus one external driver per pin
// assumes the block drives a pin only while its pin_oe bit is high
module pin_world (
    // from the block
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    // external driver set by the bench
    input wire logic [4:0] ext_val,
    input wire logic [4:0] ext_en,
    // resolved pin levels
    output logic [4:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin sits on its pull-up, never on a stale value
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// File: test/pmic_gpio_assertions.sv
// concurrent checks on the pin and sleep control block
// assumes one clock and a synchronous active-high reset
module pmic_gpio_assertions #(
    parameter int NPINS = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // pins and hold state
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic low_power_hold_state,
    // watched outputs
    input wire logic wake_request,
    input wire logic shutdown_request,
    input wire logic watchdog_service,
    input wire logic system_domain_request,
    input wire logic power_domain_request,
    input wire logic power1_domain_request,
    input wire logic calendar_hold,
    input wire logic serial_port_off,
    input wire logic [NPINS-1:0] input_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // shadow of the low page, so checks need no register reads
    logic [7:0] sh_q [32];
    logic [2:0] cmd_q;
    logic cmd_wr_q;
    wire cmd_wr = reg_wr && reg_addr == 9'h013;
    wire [7:0] slp = sh_q[20];
    wire [7:0] p01 = sh_q[21];
    wire [7:0] mode = sh_q[29];
    wire [7:0] osrc = sh_q[30];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sh_q <= '{default: 8'h00};
            cmd_q <= 3'h0;
            cmd_wr_q <= 1'b0;
        end else begin
            cmd_q <= cmd_wr ? reg_wdata[2:0] : 3'h0;
            cmd_wr_q <= cmd_wr;
            if (reg_wr && reg_addr[8:5] == 4'h0) begin
                sh_q[reg_addr[4:0]] <= reg_wdata;
            end
        end
    end

    sequence one_pulse(s);
        s ##1 !s;
    endsequence
    sequence in_hold(en);
        (low_power_hold_state && en) [*3];
    endsequence

    wake_cmd_a:
        assert property (cmd_wr && reg_wdata[2] |=> wake_request)
        else $error("wake command lost");
    shut_pulse_a:
        assert property (cmd_wr && reg_wdata[1] |=> one_pulse(shutdown_request))
        else $error("shutdown strobe not one cycle");
    wdog_pulse_a:
        assert property (cmd_wr && reg_wdata[0] |=> one_pulse(watchdog_service))
        else $error("watchdog strobe not one cycle");
    strobe_cause_a:
        assert property (shutdown_request || watchdog_service
            |-> {shutdown_request, watchdog_service} == cmd_q[1:0])
        else $error("strobe without command write");
    cmd_read_a:
        assert property (reg_rd && reg_addr == 9'h013 && !cmd_wr_q
            |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("command bits did not clear");
    dom_off_a:
        assert property (in_hold(slp[7]) |-> !(system_domain_request
            || power_domain_request || power1_domain_request))
        else $error("domain request passed in hold");
    cal_hold_a:
        assert property (in_hold(slp[4]) |-> calendar_hold)
        else $error("calendar not held");
    port_off_a:
        assert property (in_hold(slp[2]) |-> serial_port_off)
        else $error("serial port not off");
    evt_off_a:
        assert property ((low_power_hold_state && slp[0]) [*6] |-> input_event == '0)
        else $error("input event in hold");
    od_low_a:
        assert property ((p01[5:4] == 2'b10) [*3] |-> !pin_out[1])
        else $error("open-drain pin drives high");
    static_pin_a:
        assert property ((p01[1:0] == 2'b11 && osrc[2:0] == 3'h0 && $stable(mode[0])) [*3]
            |-> pin_oe[0] && pin_out[0] == mode[0])
        else $error("static output wrong");
endmodule

bind pmic_gpio_and_sleep_control pmic_gpio_assertions #(.NPINS(NPINS)) chk_i (
    .core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .pin_out, .pin_oe, .low_power_hold_state, .wake_request, .shutdown_request,
    .watchdog_service, .system_domain_request, .power_domain_request,
    .power1_domain_request, .calendar_hold, .serial_port_off, .input_event
);

// File: test/pmic_gpio_and_sleep_control_tb.sv
// self-checking bench for the pin and sleep control block
// assumes the pin model and the bound checker are compiled before it
module pmic_gpio_and_sleep_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int cd = 0, pd = 1, sy = 2, wk = 3, irq = 4, ev = 5, po = 10, gs = 15, wt = 20;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic low_power_hold_state = 1'b0, supply_fault_indication = 1'b0;
    logic power1_domain_request_in = 1'b0;
    logic [4:0] seq_pin_ctrl = 5'h00, ext_val = 5'h00, ext_en = 5'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid, wake_request, shutdown_request, watchdog_service, input_event_irq;
    logic system_domain_request, power_domain_request, power1_domain_request;
    logic calendar_hold, serial_port_off, watchdog_trigger;
    logic [4:0] pin_in, pin_out, pin_oe, input_event, gpi_state;
    int n_errors = 0, n_checks = 0;
    logic [8:0] ra [8] = '{9'h014, 9'h015, 9'h016, 9'h017, 9'h01c, 9'h01d, 9'h01e, 9'h01a};
    logic [7:0] rm [8] = '{8'h80, 8'haa, 8'haa, 8'h0a, 8'h0a, 8'h0a, 8'haa, 8'h00};
    // {expected, mode, sequencer, fault, source code}
    logic [7:0] st [8] = '{8'h60, 8'h18, 8'h69, 8'h31, 8'h09, 8'h73, 8'h2b, 8'h13};
    wire [20:0] obs = {watchdog_trigger, gpi_state, pin_out, input_event, input_event_irq, wake_request,
                       system_domain_request, power_domain_request, calendar_hold};

    pmic_gpio_and_sleep_control #(.NPINS(5), .DEB_TICK_CYCLES(2)) pmic_gpio_and_sleep_control_i (
        .core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .pin_in, .pin_out, .pin_oe, .low_power_hold_state, .supply_fault_indication,
        .seq_pin_ctrl, .power1_domain_request_in, .wake_request, .shutdown_request,
        .watchdog_service, .watchdog_trigger, .system_domain_request, .power_domain_request,
        .power1_domain_request, .calendar_hold, .serial_port_off, .input_event,
        .input_event_irq, .gpi_state
    );
    pin_world pin_world_i (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

    initial forever #5 core_clk = ~core_clk;

    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask
    task automatic cmd(input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= 9'h013;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(negedge core_clk);
        chk({5'h00, wake_request, shutdown_request, watchdog_service}, d);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, d);
        chk({6'h00, shutdown_request, watchdog_service}, 8'h00);
        @(posedge core_clk);
        rd(9'h013, 8'h00);
    endtask
    task automatic wait_for(input int b, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge core_clk);
            if (obs[b] === v) break;
        end
        chk({7'h00, obs[b]}, {7'h00, v});
        if (obs[b] !== v) print_verdict();
        @(posedge core_clk);
    endtask
    task automatic stay(input int b, input logic v, input int n);
        repeat (n) begin
            @(negedge core_clk);
            if (obs[b] !== v) chk({7'h00, obs[b]}, {7'h00, v});
        end
        chk({7'h00, obs[b]}, {7'h00, v});
        @(posedge core_clk);
    endtask
    task automatic fwd(input logic [7:0] cfg, input logic [7:0] src, input int ip, input int op);
        wr(9'h015, cfg);
        wr(9'h01d, 8'(1 << op));
        wr(9'h01e, src);
        ext_val <= 5'(1 << ip);
        wait_for(po + op, 1'b1, 12);
        ext_val <= 5'h00;
        wait_for(po + op, 1'b0, 12);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        ext_en <= 5'h01;
        @(posedge core_clk);
        wait_for(wt, 1'b1, 8);
        foreach (ra[i]) begin
            rd(ra[i], 8'h00);
            wr(ra[i], 8'haa);
            rd(ra[i], rm[i]);
            wr(ra[i], 8'h00);
        end
        for (int i = 0; i < 3; i++) cmd(8'(1 << i));
        wr(9'h015, 8'h03);
        foreach (st[i]) begin
            supply_fault_indication <= st[i][3];
            seq_pin_ctrl <= {4'h0, st[i][4]};
            wr(9'h01d, {7'h00, st[i][5]});
            wr(9'h01e, {5'h00, st[i][2:0]});
            @(negedge core_clk);
            chk({6'h00, pin_oe[0], pin_out[0]}, {7'h01, st[i][6]});
            @(posedge core_clk);
        end
        ext_en <= 5'h1f;
        fwd(8'h35, 8'h20, 0, 1);
        fwd(8'h53, 8'h05, 1, 0);
        wait_for(sy, 1'b1, 4);
        // pin3 active low input, pin2 as power domain request
        ext_val <= 5'h0c;
        wr(9'h016, 8'h14);
        wait_for(pd, 1'b1, 12);
        ext_val <= 5'h04;
        wait_for(irq, 1'b1, 14);
        wait_for(gs + 3, 1'b1, 4);
        wr(9'h00c, 8'h08);
        ext_val <= 5'h0c;
        wait_for(gs + 3, 1'b0, 12);
        ext_val <= 5'h04;
        wait_for(ev + 3, 1'b1, 14);
        stay(irq, 1'b0, 4);
        power1_domain_request_in <= 1'b1;
        wr(9'h014, 8'h95);
        low_power_hold_state <= 1'b1;
        wait_for(cd, 1'b1, 6);
        wait_for(pd, 1'b0, 6);
        ext_val <= 5'h0c;
        stay(ev + 3, 1'b0, 6);
        ext_val <= 5'h04;
        stay(ev + 3, 1'b0, 10);
        wr(9'h014, 8'h00);
        ext_val <= 5'h0c;
        stay(wk, 1'b0, 6);
        ext_val <= 5'h04;
        wait_for(wk, 1'b1, 12);
        stay(wk, 1'b0, 6);
        wr(9'h01c, 8'h08);
        wait_for(wk, 1'b1, 4);
        stay(wk, 1'b1, 4);
        wr(9'h016, 8'h94);
        wait_for(wk, 1'b0, 4);
        stay(wk, 1'b0, 6);
        low_power_hold_state <= 1'b0;
        wr(9'h010, 8'h01);
        wr(9'h01d, 8'h08);
        ext_val <= 5'h0c;
        stay(gs + 3, 1'b1, 12);
        wait_for(gs + 3, 1'b0, 40);
        print_verdict();
    end
endmodule
